/* common/stsq_cfg.svh */
`ifndef STSQ_CFG_SVH
`define STSQ_CFG_SVH

// register byte offsets
`define STSQ_OFF_MAIN 12'h000
`define STSQ_OFF_SAMPLE 12'h004
`define STSQ_OFF_STATUS 12'h008
`define STSQ_OFF_RES_A 12'h00C
`define STSQ_OFF_RES_B 12'h010
`define STSQ_OFF_LIM0 12'h020
`define STSQ_NUM_LIM 7

// main_config_reg fields
`define STSQ_MAIN_START 0
`define STSQ_MAIN_SCAN 1

// selftest_sample_config fields
`define STSQ_LEN_C_LSB 24
`define STSQ_LEN_RC_LSB 16
`define STSQ_LEN_S_LSB 8
`define STSQ_EN_LSB 0
`define STSQ_SAMPLE_RST 32'h00000000

// status fields
`define STSQ_ST_DONE 0
`define STSQ_ST_FAULT 1
`define STSQ_ST_BUSY 2
`define STSQ_ST_FAIL_LSB 3

// limit register layout
`define STSQ_LIM_MASK 32'h0FFF0FFF

// last step index of each algorithm
`define STSQ_LAST_S 5'h02
`define STSQ_LAST_RC 5'h12
`define STSQ_LAST_C 5'h10

`endif

/* common/stsq_pkg.sv */
package stsq_pkg;
    typedef enum logic [1:0] {
        STSQ_ALG_S, STSQ_ALG_RC, STSQ_ALG_C, STSQ_ALG_NONE
    } stsq_algo_t;
    typedef enum logic [1:0] {STSQ_IDLE, STSQ_SAMPLE, STSQ_CONV} stsq_state_t;
    typedef struct packed {
        stsq_algo_t algo;
        logic [4:0] step;
    } stsq_cmd_t;
    typedef struct packed {
        logic [11:0] value;
        logic [11:0] int_part;
        logic [11:0] fraction_part;
    } stsq_res_t;
    typedef struct packed {
        logic [11:0] high_limit;
        logic [11:0] low_limit;
    } stsq_lim_t;
endpackage

/* src/stsq_watchdog.sv */
// range check of one test conversion against one limit pair, or two limit pairs for supply step 1
module stsq_watchdog
    import stsq_pkg::*;
(
    input wire stsq_res_t res,
    input wire stsq_lim_t lim_a,
    input wire stsq_lim_t lim_b,
    input wire logic is_s1,
    output logic fail
);
    logic [23:0] val;
    logic [23:0] hi;
    logic [23:0] lo;

    // supply step 1 compares integer then fraction as one wide number
    always_comb begin
        if (is_s1) begin
            val = {res.int_part, res.fraction_part};
            hi = {lim_a.high_limit, lim_b.high_limit};
            lo = {lim_a.low_limit, lim_b.low_limit};
        end else begin
            val = {12'h000, res.value};
            hi = {12'h000, lim_a.high_limit};
            lo = {12'h000, lim_a.low_limit};
        end
        fail = (val > hi) || (val < lo); // equal passes
    end
endmodule

/* src/stsq_seq.sv */
// Notes on behaviour
// - supply test: bandgap/ref, supply/bandgap, ref/ref, three steps
// - supply steps run back to back, functional conversions held off
// - resistive test runs 19 steps, each a different DAC setting
// - capacitive test runs 17 steps, each a different capacitor setting
// - all test conversions use the dedicated test channel
// - enabled algorithms are scheduled from configuration bits
// - every result is range checked; any failure raises the fault line
// - each algorithm has its own sample length field, applied while running
// - sample phase lasts the programmed number of clock periods; a zero length still gives one period
// - seven limit registers, one per step group
// - supply step 1 result kept as integer and fraction parts
// - other results go to the test conversion value field
// - supply step 1 passes only inside both limits inclusive; code checks integer then fraction as one number against the joined limits
// - supply step 0 converts bandgap against the reference
// - setting the start bit begins testing, clearing it stops
// - done flag set per conversion, cleared by writing one
// - single shot and continuous scan modes
//
// Register access over APB and the address map were chosen for this implementation.
`include "stsq_cfg.svh"
module stsq_seq
    import stsq_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output stsq_cmd_t conv_cmd,
    output logic test_chan_sel,
    output logic sample_phase,
    output logic conv_go,
    output logic func_block,
    input wire logic res_valid,
    input wire stsq_res_t res,
    output logic fault_collector
);
    logic normal_conv_start;
    logic scan_mode;
    logic [31:0] selftest_sample_config;
    stsq_lim_t step_threshold_regs [`STSQ_NUM_LIM];
    logic [11:0] test_conv_value;
    logic [11:0] integer_part;
    logic [11:0] fraction_part;
    logic test_conv_done_flag;
    logic [2:0] fail_flags;
    stsq_state_t state;
    logic [7:0] cnt;
    logic wr;
    logic done_evt;
    logic wd_fail;
    logic [2:0] en;
    logic last;
    stsq_algo_t nxt;
    stsq_algo_t first;
    logic [2:0] ia;

    function automatic logic [4:0] last_step(stsq_algo_t a);
        if (a == STSQ_ALG_S) last_step = `STSQ_LAST_S;
        else if (a == STSQ_ALG_RC) last_step = `STSQ_LAST_RC;
        else last_step = `STSQ_LAST_C;
    endfunction

    // first enabled algorithm at or after position from
    function automatic stsq_algo_t pick(logic [2:0] e, logic [1:0] from);
        if (from == 2'h0 && e[0]) pick = STSQ_ALG_S;
        else if (from <= 2'h1 && e[1]) pick = STSQ_ALG_RC;
        else if (from <= 2'h2 && e[2]) pick = STSQ_ALG_C;
        else pick = STSQ_ALG_NONE;
    endfunction

    function automatic logic [7:0] samp_len(stsq_algo_t a, logic [31:0] c);
        if (a == STSQ_ALG_S) samp_len = c[`STSQ_LEN_S_LSB +: 8];
        else if (a == STSQ_ALG_RC) samp_len = c[`STSQ_LEN_RC_LSB +: 8];
        else samp_len = c[`STSQ_LEN_C_LSB +: 8];
    endfunction

    // limit register for a step; supply step 1 also uses index 2
    function automatic logic [2:0] lim_idx(stsq_algo_t a, logic [4:0] s);
        if (a == STSQ_ALG_S) lim_idx = (s == 5'h00) ? 3'h0 :
                                       (s == 5'h01) ? 3'h1 : 3'h3;
        else if (a == STSQ_ALG_RC) lim_idx = 3'h4;
        else lim_idx = (s == 5'h00) ? 3'h5 : 3'h6;
    endfunction

    assign wr = psel && penable && pready && pwrite;
    assign done_evt = (state == STSQ_CONV) && res_valid;
    assign en = selftest_sample_config[`STSQ_EN_LSB +: 3];
    assign last = conv_cmd.step == last_step(conv_cmd.algo);
    assign nxt = pick(en, 2'(conv_cmd.algo + 2'h1));
    assign first = pick(en, 2'h0);
    assign ia = lim_idx(conv_cmd.algo, conv_cmd.step);

    stsq_watchdog u_wd (
        .res(res),
        .lim_a(step_threshold_regs[ia]),
        .lim_b(step_threshold_regs[2]),
        .is_s1(conv_cmd.algo == STSQ_ALG_S && conv_cmd.step == 5'h01),
        .fail(wd_fail)
    );

    // apb answer: data captured in setup, ready in the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            if (psel && !penable) begin
                if (paddr == `STSQ_OFF_MAIN) begin
                    prdata <= {30'h0, scan_mode, normal_conv_start};
                end else if (paddr == `STSQ_OFF_SAMPLE) begin
                    prdata <= selftest_sample_config;
                end else if (paddr == `STSQ_OFF_STATUS) begin
                    prdata <= {26'h0, fail_flags, state != STSQ_IDLE,
                               fault_collector, test_conv_done_flag};
                end else if (paddr == `STSQ_OFF_RES_A) begin
                    prdata <= {20'h0, test_conv_value};
                end else if (paddr == `STSQ_OFF_RES_B) begin
                    prdata <= {4'h0, integer_part, 4'h0, fraction_part};
                end else if (paddr >= `STSQ_OFF_LIM0 && paddr[1:0] == 2'h0
                    && paddr < `STSQ_OFF_LIM0 + 12'h01C) begin
                    prdata <= {4'h0,
                        step_threshold_regs[3'(paddr[4:2])].high_limit,
                        4'h0, step_threshold_regs[3'(paddr[4:2])].low_limit};
                end else begin
                    pslverr <= 1'b1; // unmapped address
                end
            end
        end
    end

    // configuration and limit registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            selftest_sample_config <= `STSQ_SAMPLE_RST;
            scan_mode <= 1'b0;
            for (int i = 0; i < `STSQ_NUM_LIM; i++) begin
                step_threshold_regs[i] <= '0;
            end
        end else if (wr) begin
            if (paddr == `STSQ_OFF_SAMPLE) begin
                selftest_sample_config <= pwdata;
            end else if (paddr == `STSQ_OFF_MAIN) begin
                scan_mode <= pwdata[`STSQ_MAIN_SCAN];
            end else if (paddr >= `STSQ_OFF_LIM0 && paddr[1:0] == 2'h0
                && paddr < `STSQ_OFF_LIM0 + 12'h01C) begin
                // 12-bit halves only; other bits are dropped
                step_threshold_regs[3'(paddr[4:2])] <=
                    {pwdata[27:16], pwdata[11:0]};
            end
        end
    end

    // start bit: software sets and clears, single shot ends it itself
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            normal_conv_start <= 1'b0;
        end else if (wr && paddr == `STSQ_OFF_MAIN) begin
            normal_conv_start <= pwdata[`STSQ_MAIN_START];
        end else if (done_evt && last && nxt == STSQ_ALG_NONE
                     && !scan_mode) begin
            normal_conv_start <= 1'b0;
        end
    end

    // sticky flags: a new event beats a same-cycle clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            test_conv_done_flag <= 1'b0;
            fault_collector <= 1'b0;
            fail_flags <= 3'h0;
        end else begin
            if (done_evt) begin
                test_conv_done_flag <= 1'b1;
            end else if (wr && paddr == `STSQ_OFF_STATUS
                         && pwdata[`STSQ_ST_DONE]) begin
                test_conv_done_flag <= 1'b0;
            end
            if (done_evt && wd_fail) begin
                fault_collector <= 1'b1;
                fail_flags[conv_cmd.algo] <= 1'b1;
            end else if (wr && paddr == `STSQ_OFF_STATUS
                         && pwdata[`STSQ_ST_FAULT]) begin
                fault_collector <= 1'b0;
                fail_flags <= 3'h0;
            end
        end
    end

    // result capture; supply step 1 goes to the split register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            test_conv_value <= 12'h000;
            integer_part <= 12'h000;
            fraction_part <= 12'h000;
        end else if (done_evt) begin
            if (conv_cmd.algo == STSQ_ALG_S && conv_cmd.step == 5'h01) begin
                integer_part <= res.int_part;
                fraction_part <= res.fraction_part;
            end else begin
                test_conv_value <= res.value;
            end
        end
    end

    // sequencer; a stop request waits for the end of a supply pass
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= STSQ_IDLE;
            conv_cmd <= '{algo: STSQ_ALG_NONE, step: 5'h00};
            cnt <= 8'h00;
            sample_phase <= 1'b0;
            conv_go <= 1'b0;
            test_chan_sel <= 1'b0;
            func_block <= 1'b0;
        end else begin
            conv_go <= 1'b0;
            case (state)
                STSQ_IDLE: begin
                    if (normal_conv_start && first != STSQ_ALG_NONE) begin
                        state <= STSQ_SAMPLE;
                        conv_cmd <= '{algo: first, step: 5'h00};
                        cnt <= samp_len(first, selftest_sample_config);
                        sample_phase <= 1'b1;
                        test_chan_sel <= 1'b1;
                        func_block <= first == STSQ_ALG_S;
                    end
                end
                STSQ_SAMPLE: begin
                    // a zero length still samples one period
                    if (cnt <= 8'h01) begin
                        sample_phase <= 1'b0;
                        conv_go <= 1'b1;
                        state <= STSQ_CONV;
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
                STSQ_CONV: begin
                    if (res_valid) begin
                        if (!last && (normal_conv_start
                            || conv_cmd.algo == STSQ_ALG_S)) begin
                            // next step of this algorithm
                            state <= STSQ_SAMPLE;
                            conv_cmd.step <= conv_cmd.step + 5'h01;
                            cnt <= samp_len(conv_cmd.algo,
                                            selftest_sample_config);
                            sample_phase <= 1'b1;
                        end else if (last && normal_conv_start
                            && (nxt != STSQ_ALG_NONE
                                || (scan_mode && first != STSQ_ALG_NONE)))
                        begin
                            // next algorithm, or wrap in scan mode
                            state <= STSQ_SAMPLE;
                            conv_cmd.algo <= (nxt != STSQ_ALG_NONE) ? nxt
                                                                    : first;
                            conv_cmd.step <= 5'h00;
                            cnt <= samp_len((nxt != STSQ_ALG_NONE) ? nxt
                                : first, selftest_sample_config);
                            sample_phase <= 1'b1;
                            func_block <= ((nxt != STSQ_ALG_NONE) ? nxt
                                : first) == STSQ_ALG_S;
                        end else begin
                            state <= STSQ_IDLE;
                            conv_cmd <= '{algo: STSQ_ALG_NONE, step: 5'h00};
                            test_chan_sel <= 1'b0;
                            func_block <= 1'b0;
                        end
                    end
                end
                default: state <= STSQ_IDLE;
            endcase
        end
    end

    // helper: sample length seen at the start of each sample phase
    logic [7:0] h_len;
    logic [7:0] h_run;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            h_len <= 8'h00;
            h_run <= 8'h00;
        end else if (!sample_phase) begin
            h_run <= 8'h00;
            // a scan wrap has no next algorithm and restarts at the first
            h_len <= (state == STSQ_CONV && !last) ? samp_len(conv_cmd.algo,
                selftest_sample_config) : samp_len((res_valid
                && nxt != STSQ_ALG_NONE) ? nxt : first,
                selftest_sample_config);
        end else begin
            h_run <= h_run + 8'h01;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sample_length_a: assert property ($fell(sample_phase) |->
        h_run == ((h_len == 8'h00) ? 8'h01 : h_len))
        else $error("sample phase length differs from programmed value");
    go_after_sample_a: assert property ($fell(sample_phase) |->
        conv_go && state == STSQ_CONV)
        else $error("no conversion start after sample phase");
    test_channel_a: assert property (sample_phase |->
        test_chan_sel)
        else $error("sampling outside the test channel");
    supply_atomic_a: assert property ((conv_cmd.algo == STSQ_ALG_S
        && state != STSQ_IDLE) |-> func_block)
        else $error("supply pass not held atomic");
    done_flag_a: assert property (done_evt |=>
        test_conv_done_flag)
        else $error("done flag not set after conversion");
    fault_raise_a: assert property ((done_evt && wd_fail) |=>
        fault_collector && fail_flags[$past(conv_cmd.algo)])
        else $error("failed step did not raise fault");
    split_result_a: assert property ((done_evt && conv_cmd.step == 5'h01
        && conv_cmd.algo == STSQ_ALG_S) |=>
        integer_part == $past(res.int_part)
        && fraction_part == $past(res.fraction_part))
        else $error("supply step 1 result not split");
    step_advance_a: assert property ((done_evt && !last
        && normal_conv_start) |=> conv_cmd.step == $past(conv_cmd.step)
        + 5'h01 ##0 sample_phase)
        else $error("step did not advance");
    single_stop_a: assert property ((done_evt && last
        && nxt == STSQ_ALG_NONE && !scan_mode && !wr) |=>
        state == STSQ_IDLE && !normal_conv_start)
        else $error("single shot did not end");

    s1_seen_c: cover property (done_evt && conv_cmd.algo == STSQ_ALG_S
        && conv_cmd.step == 5'h01);
    fault_seen_c: cover property (done_evt && wd_fail);
    scan_wrap_c: cover property (done_evt && last && scan_mode
        && nxt == STSQ_ALG_NONE && normal_conv_start);
    cap_end_c: cover property (done_evt && conv_cmd.algo == STSQ_ALG_C
        && last);
endmodule

/* sim/stsq_core_model.sv */
// converter core stand-in: answers each go pulse after a settable delay
module stsq_core_model
    import stsq_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire stsq_cmd_t conv_cmd,
    input wire logic test_chan_sel,
    input wire logic sample_phase,
    input wire logic conv_go,
    input wire logic func_block,
    input wire logic [7:0] delay,
    input wire stsq_algo_t bad_algo,
    input wire logic [4:0] bad_step,
    input wire logic [11:0] bad_val,
    output logic res_valid,
    output stsq_res_t res,
    output int cnt [0:2],
    output int slen [0:2],
    output int viol
);
    timeunit 1ns;
    timeprecision 1ps;
    stsq_cmd_t cmd_q;
    logic busy;
    logic bad;
    logic [7:0] wait_cnt;
    int scnt;
    int n_steps;

    // the one step that answers out of range, when the bench asks for it
    assign bad = cmd_q.algo == bad_algo && cmd_q.step == bad_step;
    assign n_steps = (conv_cmd.algo == STSQ_ALG_S) ? 3 :
        (conv_cmd.algo == STSQ_ALG_RC) ? 19 : 17;

    // one process so sample length, step walk and answer stay in step
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 3; i++) begin
                cnt[i] <= 0;
                slen[i] <= 0;
            end
            viol <= 0;
            scnt <= 0;
            busy <= 1'b0;
            wait_cnt <= 8'h00;
            cmd_q <= '0;
            res_valid <= 1'b0;
            res <= '0;
        end else begin
            res_valid <= 1'b0;
            res <= ~res; // no hold time, so never leave stale data showing
            if (sample_phase) begin
                scnt <= scnt + 1;
            end
            if (conv_go) begin
                slen[conv_cmd.algo] <= scnt;
                scnt <= 0;
                cmd_q <= conv_cmd;
                busy <= 1'b1;
                wait_cnt <= delay;
                if (!test_chan_sel || conv_cmd.algo == STSQ_ALG_NONE ||
                    int'(conv_cmd.step) != cnt[conv_cmd.algo] % n_steps ||
                    (conv_cmd.algo == STSQ_ALG_S && !func_block)) begin
                    viol <= viol + 1;
                end
            end else if (busy && wait_cnt != 8'h00) begin
                wait_cnt <= wait_cnt - 8'h01;
            end else if (busy) begin
                busy <= 1'b0;
                res_valid <= 1'b1;
                cnt[cmd_q.algo] <= cnt[cmd_q.algo] + 1;
                res.value <= bad ? bad_val : 12'hA00 - {7'h00, cmd_q.step};
                res.int_part <= 12'h003;
                res.fraction_part <= bad ? 12'h3DA : 12'h3D9;
            end
        end
    end
endmodule

/* sim/test_adc_selftest_sequencer.sv */
`include "stsq_cfg.svh"
module test_adc_selftest_sequencer import stsq_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    stsq_cmd_t conv_cmd;
    logic test_chan_sel;
    logic sample_phase;
    logic conv_go;
    logic func_block;
    logic res_valid;
    stsq_res_t res;
    logic fault_collector;
    logic [7:0] delay;
    stsq_algo_t bad_algo;
    logic [4:0] bad_step;
    logic [11:0] bad_val;
    int cnt [0:2];
    int slen [0:2];
    int viol;
    int n_errors;
    int samples_checked;
    logic [31:0] rdata;
    logic rerr;

    stsq_seq u_stsq_seq (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .conv_cmd(conv_cmd), .test_chan_sel(test_chan_sel),
        .sample_phase(sample_phase), .conv_go(conv_go),
        .func_block(func_block), .res_valid(res_valid), .res(res),
        .fault_collector(fault_collector));

    stsq_core_model u_stsq_core_model (.pclk(pclk), .presetn(presetn),
        .conv_cmd(conv_cmd), .test_chan_sel(test_chan_sel),
        .sample_phase(sample_phase), .conv_go(conv_go),
        .func_block(func_block), .delay(delay), .bad_algo(bad_algo),
        .bad_step(bad_step), .bad_val(bad_val), .res_valid(res_valid),
        .res(res), .cnt(cnt), .slen(slen), .viol(viol));

    // 125 MHz
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic end_of_test;
        $display("compared %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic cmp32(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cmpn(input string nm, input int e, input int g);
        samples_checked++;
        if (g != e) begin
            n_errors++;
            $display("BAD %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    // one apb transfer; the leading edge keeps transfers from abutting
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        if (pready !== 1'b1) n_errors++;
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input string nm, input logic [11:0] a,
        input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        cmp32(nm, e, rdata);
    endtask

    // bounded: wait for the run to start, then poll busy until it clears
    task automatic wait_end;
        int n;
        n = 0;
        while (test_chan_sel !== 1'b1 && n < 100) begin
            @(posedge pclk);
            n++;
        end
        n = 0;
        do begin
            apb(1'b0, `STSQ_OFF_STATUS, 32'h0);
            n++;
        end while (rdata[`STSQ_ST_BUSY] !== 1'b0 && n < 4000);
    endtask

    task automatic run_single(input logic [31:0] cfg, input logic [31:0] st);
        apb(1'b1, `STSQ_OFF_SAMPLE, cfg);
        apb(1'b1, `STSQ_OFF_MAIN, 32'h1);
        wait_end();
        rd_chk("status", `STSQ_OFF_STATUS, st);
        cmp32("fault", {31'h0, st[1]}, {31'h0, fault_collector});
        rd_chk("main", `STSQ_OFF_MAIN, 32'h0);
        apb(1'b1, `STSQ_OFF_STATUS, 32'h3);
        rd_chk("status clr", `STSQ_OFF_STATUS, 32'h0);
        cmp32("fault clr", 32'h0, {31'h0, fault_collector});
    endtask

    function automatic logic [31:0] lim(input int i);
        return i == 1 ? 32'h00030002 : i == 2 ? 32'h03D901E3 : 32'h0A000600;
    endfunction

    initial begin
        logic [31:0] cfgs [0:2];
        stsq_algo_t algs [0:2];
        cfgs = '{32'h1860FF02, 32'h1860FF04, 32'h1860FF01};
        algs = '{STSQ_ALG_RC, STSQ_ALG_C, STSQ_ALG_S};
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        delay = 8'h00;
        bad_algo = STSQ_ALG_NONE;
        bad_step = 5'h00;
        bad_val = 12'h000;
        n_errors = 0;
        samples_checked = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        cmp32("cmd rst", 32'h60, {25'h0, conv_cmd});
        rd_chk("main rst", `STSQ_OFF_MAIN, 32'h0);
        rd_chk("cfg rst", `STSQ_OFF_SAMPLE, `STSQ_SAMPLE_RST);
        rd_chk("status rst", `STSQ_OFF_STATUS, 32'h0);
        rd_chk("unmapped", 12'h014, 32'h0);
        cmp32("slverr", 32'h1, {31'h0, rerr});
        apb(1'b1, `STSQ_OFF_LIM0, 32'hFFFFFFFF);
        rd_chk("lim mask", `STSQ_OFF_LIM0, `STSQ_LIM_MASK);
        // limits loaded before any run starts
        for (int i = 0; i < `STSQ_NUM_LIM; i++) begin
            apb(1'b1, `STSQ_OFF_LIM0 + 12'(4 * i), lim(i));
            rd_chk("limit", `STSQ_OFF_LIM0 + 12'(4 * i), lim(i));
        end
        // all three algorithms, recommended sample lengths
        run_single(32'h1860FF07, 32'h1);
        cmpn("s steps", 3, cnt[0]);
        cmpn("rc steps", 19, cnt[1]);
        cmpn("c steps", 17, cnt[2]);
        cmpn("s len", 255, slen[0]);
        cmpn("rc len", 96, slen[1]);
        cmpn("c len", 24, slen[2]);
        rd_chk("res a", `STSQ_OFF_RES_A, 32'h9F0);
        // supply only, slow answers; step 1 sits on its high limits
        delay <= 8'h05;
        run_single(32'h1860FF01, 32'h1);
        rd_chk("res a", `STSQ_OFF_RES_A, 32'h9FE);
        rd_chk("res b", `STSQ_OFF_RES_B, 32'h000303D9);
        // one step out of range per algorithm, each just past a limit
        for (int i = 0; i < 3; i++) begin
            delay <= 8'(40 - 20 * i);
            bad_algo <= algs[i];
            bad_step <= i == 0 ? 5'h07 : i == 1 ? 5'h00 : 5'h01;
            bad_val <= i == 0 ? 12'hA01 : 12'h5FF;
            run_single(cfgs[i], 32'h3 | (32'h8 << algs[i]));
        end
        cmpn("s total", 9, cnt[0]);
        bad_algo <= STSQ_ALG_NONE;
        // continuous scan, stopped in mid run
        apb(1'b1, `STSQ_OFF_MAIN, 32'h3);
        for (int n = 0; n < 6000 && cnt[0] < 13; n++) @(posedge pclk);
        apb(1'b1, `STSQ_OFF_MAIN, 32'h2);
        wait_end();
        cmpn("s whole", 0, cnt[0] % 3);
        cmpn("s scan", 1, int'(cnt[0] >= 15));
        rd_chk("main stop", `STSQ_OFF_MAIN, 32'h2);
        cmpn("order", 0, viol);
        end_of_test();
    end

    // the longest run, all three algorithms in one pass, needs about 3100 cycles
    initial begin
        repeat (60000) @(posedge pclk);
        n_errors++;
        end_of_test();
    end
endmodule
